/* verilog/dic_pkg.sv */
// Shared constants and types for the digital input conditioning block.
// Assumes a single 40 MHz clock and an AXI4-Lite register port with 32-bit data.
package dic_pkg;
	// Clock and control cycle timing
	localparam int MCLK_NS = 25;
	localparam int CTRL_CYC_NS = 1000;
	localparam int CTRL_DIV = (CTRL_CYC_NS + MCLK_NS - 1) / MCLK_NS;
	localparam logic [5:0] CTRL_DIV_LAST = 6'(CTRL_DIV - 1);

	// Input counts and widths
	localparam int NIN = 8;
	localparam int GRP = 4;
	localparam int FLT_W = 10;

	// Register byte offsets
	localparam logic [7:0] OFS_SRC_LO = 8'h00;
	localparam logic [7:0] OFS_SRC_HI = 8'h04;
	localparam logic [7:0] OFS_FLT = 8'h08;
	localparam logic [7:0] OFS_ALM = 8'h0c;
	localparam logic [7:0] OFS_INV = 8'h10;
	localparam logic [7:0] OFS_CTRL = 8'h14;
	localparam logic [7:0] OFS_STAT = 8'h18;
	localparam logic [7:0] OFS_MST = 8'h1c;

	// Field positions
	localparam int CTRL_RESTART_BIT = 0;
	localparam int STAT_ALARM_BIT = 8;
	localparam int STAT_ACT_LSB = 16;

	// Reset values and limits
	localparam logic [3:0] SRC_RST = 4'h0;
	localparam logic [3:0] INV_RST = 4'h0;
	localparam logic [FLT_W-1:0] FLT_RST = 10'h001;
	localparam logic [FLT_W-1:0] FLT_MAX = 10'h3e8;
	localparam logic [1:0] ALM_RST = 2'h1;

	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Restart-latched configuration
	typedef struct packed {
		logic [GRP-1:0] src_lo;
		logic [GRP-1:0] src_hi;
		logic [GRP-1:0] inv;
	} dic_cfg_t;

	localparam dic_cfg_t CFG_RST = '{src_lo: SRC_RST, src_hi: SRC_RST, inv: INV_RST};
endpackage : dic_pkg

/* verilog/dic_filter.sv */
// Stability filter for one conditioned signal.
// Assumes tick_i is a one-cycle enable once per control cycle on the same clock.
`timescale 1ns/10ps
module dic_filter
	import dic_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Control
	input wire logic tick_i,
	input wire logic [FLT_W-1:0] time_i,
	// Signal
	input wire logic raw_i,
	output logic filt_o
);
	logic filt_q;
	logic filt_d;
	logic [FLT_W-1:0] cnt_q;
	logic [FLT_W-1:0] cnt_d;

	// Level passes on only after staying different for time_i ticks
	always_comb begin
		filt_d = filt_q;
		cnt_d = cnt_q;
		if (tick_i) begin
			if (raw_i == filt_q) begin
				cnt_d = '0;
			end else if ((cnt_q + 10'h001) >= time_i) begin
				filt_d = raw_i;
				cnt_d = '0;
			end else begin
				cnt_d = cnt_q + 10'h001;
			end
		end
	end

	// State registers
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			filt_q <= 1'b0;
			cnt_q <= '0;
		end else begin
			filt_q <= filt_d;
			cnt_q <= cnt_d;
		end
	end

	assign filt_o = filt_q;

	a_filt_no_early: assert property (@(posedge mclk_i) disable iff (rst_i)
		(tick_i && raw_i != filt_q && (cnt_q + 10'h001) < time_i) |=> $stable(filt_q))
		else $error("filter output changed before the filter time");
	a_filt_take_new: assert property (@(posedge mclk_i) disable iff (rst_i)
		(tick_i && raw_i != filt_q && (cnt_q + 10'h001) >= time_i) |=> filt_q == $past(raw_i))
		else $error("filter did not pass the stable level");
	a_filt_only_tick: assert property (@(posedge mclk_i) disable iff (rst_i)
		!tick_i |=> $stable(filt_q))
		else $error("filter output changed outside a control cycle");
endmodule : dic_filter

/* verilog/dic_top.sv */
// Digital input conditioning: source select, filtering, inversion, alarm filter.
// Assumes terminals are asynchronous pins and alarm_i comes from same-clock logic.
`timescale 1ns/10ps
module dic_top
	import dic_pkg::*;
(
	// Clock and reset
	input wire logic mclk_i,
	input wire logic rst_i,
	// Pins and internal alarm
	input wire logic [NIN-1:0] term_i,
	input wire logic alarm_i,
	// Conditioned outputs
	output logic [NIN-1:0] din_o,
	output logic alarm_o,
	// AXI4-Lite write address and data
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [7:0] s_axi_awaddr_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	// AXI4-Lite write response
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	output logic [1:0] s_axi_bresp_o,
	// AXI4-Lite read
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	input wire logic [7:0] s_axi_araddr_i,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o
);
	// Register group state
	dic_cfg_t cfg_q, cfg_d, act_q, act_d;
	logic [FLT_W-1:0] flt_q, flt_d;
	logic [1:0] alm_q, alm_d;
	logic [NIN-1:0] mst_q, mst_d;
	logic restart_q, restart_d;
	logic aw_hold_q, aw_hold_d, w_hold_q, w_hold_d;
	logic [7:0] awaddr_q, awaddr_d;
	logic [31:0] wdata_q, wdata_d;
	logic [3:0] wstrb_q, wstrb_d;
	logic awready_q, awready_d, wready_q, wready_d;
	logic bvalid_q, bvalid_d;
	logic [1:0] bresp_q, bresp_d;
	logic arready_q, arready_d, rvalid_q, rvalid_d;
	logic [31:0] rdata_q, rdata_d;
	logic [1:0] rresp_q, rresp_d;
	logic [15:0] wval;
	logic do_wr;

	// Data path state
	logic [5:0] div_q, div_d;
	logic tick_q, tick_d;
	logic [NIN-1:0] term_m_q, term_s_q;
	logic [NIN-1:0] raw;
	logic [NIN-1:0] filt;
	logic [NIN-1:0] din_q, din_d;
	logic alm_filt;
	logic alarm_q, alarm_d;
	logic [FLT_W-1:0] alm_time;

	// Merge the low two byte lanes into a 16-bit register value
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] data,
		input logic [3:0] strb);
		return {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
	endfunction : merge16

	// Write takes place once both address and data are held and no response waits
	assign do_wr = aw_hold_q && w_hold_q && !bvalid_q;

	// Register bus and configuration, next values
	always_comb begin
		cfg_d = cfg_q;
		act_d = act_q;
		flt_d = flt_q;
		alm_d = alm_q;
		mst_d = mst_q;
		restart_d = 1'b0;
		aw_hold_d = aw_hold_q;
		w_hold_d = w_hold_q;
		awaddr_d = awaddr_q;
		wdata_d = wdata_q;
		wstrb_d = wstrb_q;
		bvalid_d = bvalid_q;
		bresp_d = bresp_q;
		arready_d = arready_q;
		rvalid_d = rvalid_q;
		rdata_d = rdata_q;
		rresp_d = rresp_q;
		wval = 16'h0000;
		// Restart copies pending fields into the working set
		if (restart_q) begin
			act_d = cfg_q;
		end
		if (bvalid_q && s_axi_bready_i) begin
			bvalid_d = 1'b0;
		end
		if (do_wr) begin
			aw_hold_d = 1'b0;
			w_hold_d = 1'b0;
			bvalid_d = 1'b1;
			bresp_d = RESP_OKAY;
			case (awaddr_q)
				OFS_SRC_LO: begin
					wval = merge16({12'h000, cfg_q.src_lo}, wdata_q, wstrb_q);
					cfg_d.src_lo = wval[3:0];
				end
				OFS_SRC_HI: begin
					wval = merge16({12'h000, cfg_q.src_hi}, wdata_q, wstrb_q);
					cfg_d.src_hi = wval[3:0];
				end
				OFS_FLT: begin
					wval = merge16({6'h00, flt_q}, wdata_q, wstrb_q);
					// Out-of-range settings saturate rather than wrap
					flt_d = (wval > 16'(FLT_MAX)) ? FLT_MAX : wval[FLT_W-1:0];
				end
				OFS_ALM: begin
					wval = merge16({14'h0000, alm_q}, wdata_q, wstrb_q);
					alm_d = wval[1:0];
				end
				OFS_INV: begin
					wval = merge16({12'h000, cfg_q.inv}, wdata_q, wstrb_q);
					cfg_d.inv = wval[3:0];
				end
				OFS_CTRL: restart_d = wstrb_q[0] && wdata_q[CTRL_RESTART_BIT];
				OFS_MST: begin
					wval = merge16({8'h00, mst_q}, wdata_q, wstrb_q);
					mst_d = wval[NIN-1:0];
				end
				OFS_STAT: bresp_d = RESP_OKAY;
				default: bresp_d = RESP_SLVERR;
			endcase
		end
		if (s_axi_awvalid_i && awready_q) begin
			aw_hold_d = 1'b1;
			awaddr_d = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && wready_q) begin
			w_hold_d = 1'b1;
			wdata_d = s_axi_wdata_i;
			wstrb_d = s_axi_wstrb_i;
		end
		awready_d = !aw_hold_d;
		wready_d = !w_hold_d;
		// Read answers one cycle after the address is taken
		if (rvalid_q && s_axi_rready_i) begin
			rvalid_d = 1'b0;
			arready_d = 1'b1;
		end
		if (s_axi_arvalid_i && arready_q) begin
			arready_d = 1'b0;
			rvalid_d = 1'b1;
			rresp_d = RESP_OKAY;
			case (s_axi_araddr_i)
				OFS_SRC_LO: rdata_d = {28'h0000000, cfg_q.src_lo};
				OFS_SRC_HI: rdata_d = {28'h0000000, cfg_q.src_hi};
				OFS_FLT: rdata_d = {22'h000000, flt_q};
				OFS_ALM: rdata_d = {30'h00000000, alm_q};
				OFS_INV: rdata_d = {28'h0000000, cfg_q.inv};
				OFS_CTRL: rdata_d = 32'h00000000;
				OFS_STAT: rdata_d = {4'h0, act_q, 7'h00, alarm_q, din_q};
				OFS_MST: rdata_d = {24'h000000, mst_q};
				default: begin
					rdata_d = 32'h00000000;
					rresp_d = RESP_SLVERR;
				end
			endcase
		end
	end

	// Register bus and configuration, registers
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			cfg_q <= CFG_RST;
			act_q <= CFG_RST;
			flt_q <= FLT_RST;
			alm_q <= ALM_RST;
			mst_q <= 8'h00;
			restart_q <= 1'b0;
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= 8'h00;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h00000000;
			rresp_q <= RESP_OKAY;
		end else begin
			cfg_q <= cfg_d;
			act_q <= act_d;
			flt_q <= flt_d;
			alm_q <= alm_d;
			mst_q <= mst_d;
			restart_q <= restart_d;
			aw_hold_q <= aw_hold_d;
			w_hold_q <= w_hold_d;
			awaddr_q <= awaddr_d;
			wdata_q <= wdata_d;
			wstrb_q <= wstrb_d;
			awready_q <= awready_d;
			wready_q <= wready_d;
			bvalid_q <= bvalid_d;
			bresp_q <= bresp_d;
			arready_q <= arready_d;
			rvalid_q <= rvalid_d;
			rdata_q <= rdata_d;
			rresp_q <= rresp_d;
		end
	end

	// Terminal synchronisers, first stage read only by the second
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			term_m_q <= 8'h00;
			term_s_q <= 8'h00;
		end else begin
			term_m_q <= term_i;
			term_s_q <= term_m_q;
		end
	end

	// Source select per input, then one filter each
	for (genvar i = 0; i < NIN; i++) begin : g_in
		if (i < GRP) begin : g_lo
			assign raw[i] = act_q.src_lo[i] ? mst_q[i] : term_s_q[i];
		end else begin : g_hi
			assign raw[i] = act_q.src_hi[i-GRP] ? mst_q[i] : term_s_q[i];
		end
		dic_filter u_flt (
			.mclk_i(mclk_i),
			.rst_i(rst_i),
			.tick_i(tick_q),
			.time_i(flt_q),
			.raw_i(raw[i]),
			.filt_o(filt[i])
		);
	end

	// Alarm filter counts in units of two control cycles
	assign alm_time = {7'h00, alm_q, 1'b0};
	dic_filter u_alm (
		.mclk_i(mclk_i),
		.rst_i(rst_i),
		.tick_i(tick_q),
		.time_i(alm_time),
		.raw_i(alarm_i),
		.filt_o(alm_filt)
	);

	// Control cycle divider and output stage, next values
	always_comb begin
		tick_d = (div_q == CTRL_DIV_LAST);
		div_d = tick_d ? 6'h00 : div_q + 6'h01;
		din_d = filt ^ {4'h0, act_q.inv};
		alarm_d = alm_filt;
	end

	// Control cycle divider and output stage, registers
	always_ff @(posedge mclk_i or posedge rst_i) begin
		if (rst_i) begin
			div_q <= 6'h00;
			tick_q <= 1'b0;
			din_q <= 8'h00;
			alarm_q <= 1'b0;
		end else begin
			div_q <= div_d;
			tick_q <= tick_d;
			din_q <= din_d;
			alarm_q <= alarm_d;
		end
	end

	// Outputs straight from flip-flops
	assign din_o = din_q;
	assign alarm_o = alarm_q;
	assign s_axi_awready_o = awready_q;
	assign s_axi_wready_o = wready_q;
	assign s_axi_bvalid_o = bvalid_q;
	assign s_axi_bresp_o = bresp_q;
	assign s_axi_arready_o = arready_q;
	assign s_axi_rvalid_o = rvalid_q;
	assign s_axi_rdata_o = rdata_q;
	assign s_axi_rresp_o = rresp_q;

	a_src_lo_mux: assert property (@(posedge mclk_i) disable iff (rst_i)
		raw[3:0] == ((act_q.src_lo & mst_q[3:0]) | (~act_q.src_lo & term_s_q[3:0])))
		else $error("low group source select wrong");
	a_src_hi_mux: assert property (@(posedge mclk_i) disable iff (rst_i)
		raw[7:4] == ((act_q.src_hi & mst_q[7:4]) | (~act_q.src_hi & term_s_q[7:4])))
		else $error("high group source select wrong");
	a_flt_range: assert property (@(posedge mclk_i) disable iff (rst_i)
		flt_q <= FLT_MAX)
		else $error("input filter time above limit");
	a_reset_defaults: assert property (@(posedge mclk_i)
		$fell(rst_i) |-> (flt_q == FLT_RST && alm_q == ALM_RST && act_q == CFG_RST))
		else $error("defaults wrong after reset");
	a_alarm_units: assert property (@(posedge mclk_i) disable iff (rst_i)
		(tick_q && alm_q != 2'h0 && alarm_i != alm_filt && u_alm.cnt_q == '0) |=> $stable(alm_filt))
		else $error("alarm filter passed a change within one control cycle");
	a_inv_apply: assert property (@(posedge mclk_i) disable iff (rst_i)
		##1 din_q == ($past(filt) ^ {4'h0, $past(act_q.inv)}))
		else $error("inversion not applied to output");
	a_cfg_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
		!restart_q |=> $stable(act_q))
		else $error("working config changed without restart");
	a_cfg_load: assert property (@(posedge mclk_i) disable iff (rst_i)
		restart_q |=> act_q == $past(cfg_q))
		else $error("restart did not load config");
	a_tick_period: assert property (@(posedge mclk_i) disable iff (rst_i)
		tick_q |=> !tick_q [*3])
		else $error("control cycle tick too frequent");
	a_bvalid_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
		(bvalid_q && !s_axi_bready_i) |=> bvalid_q && $stable(bresp_q))
		else $error("write response dropped before ready");

	c_restart: cover property (@(posedge mclk_i) disable iff (rst_i) restart_q);
	c_din_change: cover property (@(posedge mclk_i) disable iff (rst_i) din_q != $past(din_q));
	c_alarm_rise: cover property (@(posedge mclk_i) disable iff (rst_i) $rose(alarm_q));
endmodule : dic_top

/* test/dic_term_model.sv */
// Model of the input terminals as wired switch contacts.
// Assumes the bench sets the wanted level; contacts bounce before settling.
`timescale 1ns/10ps
module dic_term_model #(
	parameter int BOUNCE = 8
) (
	// Clock
	input wire logic mclk_i,
	// Wanted contact levels
	input wire logic [7:0] level_i,
	// Terminal pins
	output logic [7:0] term_o
);
	logic [7:0] last_q;
	logic [7:0] chg_q;
	int cnt_q;

	initial begin
		term_o = 8'h00;
		last_q = 8'h00;
		chg_q = 8'h00;
		cnt_q = 0;
	end

	// Changed contacts chatter between old and new level before they settle
	always @(posedge mclk_i) begin
		if (level_i !== last_q) begin
			chg_q <= level_i ^ last_q;
			last_q <= level_i;
			cnt_q <= BOUNCE;
		end else if (cnt_q > 0) begin
			cnt_q <= cnt_q - 1;
		end
		term_o <= (cnt_q > 0 && cnt_q[0]) ? (last_q ^ chg_q) : last_q;
	end
endmodule : dic_term_model

/* test/testbench.sv */
// Self-checking bench for the digital input conditioning block.
// Assumes the package, design and terminal model compile first.
`timescale 1ns/10ps
module testbench;
	import dic_pkg::*;
	logic mclk_i, rst_i, alarm_i, alarm_o;
	logic [7:0] lvl, term, din, awa, ara;
	logic awv, awr, wv, wrdy, bv, arv, arr, rv;
	logic [31:0] wd, rd;
	logic [1:0] bresp, rresp, r;
	int fail_count, samples_checked, cyc;

	dic_term_model u_term (.mclk_i(mclk_i), .level_i(lvl), .term_o(term));

	dic_top dut (.mclk_i(mclk_i), .rst_i(rst_i), .term_i(term), .alarm_i(alarm_i),
		.din_o(din), .alarm_o(alarm_o), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
		.s_axi_awaddr_i(awa), .s_axi_wvalid_i(wv), .s_axi_wready_o(wrdy),
		.s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_bvalid_o(bv),
		.s_axi_bready_i(1'b1), .s_axi_bresp_o(bresp), .s_axi_arvalid_i(arv),
		.s_axi_arready_o(arr), .s_axi_araddr_i(ara), .s_axi_rvalid_o(rv),
		.s_axi_rready_i(1'b1), .s_axi_rdata_o(rd), .s_axi_rresp_o(rresp));

	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// Whole control cycles; ready is held high so only valids move
	task tk(input int n);
		repeat (n * CTRL_DIV) @(posedge mclk_i);
	endtask : tk

	task axw(input logic [7:0] a, input logic [31:0] d);
		logic done;
		done = 0;
		awv <= 1'b1;
		awa <= a;
		wv <= 1'b1;
		wd <= d;
		while (!done) begin
			@(posedge mclk_i);
			if (awv && awr) awv <= 1'b0;
			if (wv && wrdy) wv <= 1'b0;
			if (bv) begin
				r = bresp;
				done = 1;
			end
		end
	endtask : axw

	task rck(input string nm, input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		logic done;
		done = 0;
		arv <= 1'b1;
		ara <= a;
		while (!done) begin
			@(posedge mclk_i);
			if (arv && arr) arv <= 1'b0;
			if (rv) begin
				chk(nm, rd, e);
				chk(nm, {30'h0, rresp}, {30'h0, er});
				done = 1;
			end
		end
	endtask : rck

	task t_reset;
		rck("src_lo", OFS_SRC_LO, 32'h0, RESP_OKAY);
		rck("src_hi", OFS_SRC_HI, 32'h0, RESP_OKAY);
		rck("flt", OFS_FLT, 32'h1, RESP_OKAY);
		rck("alm", OFS_ALM, 32'h1, RESP_OKAY);
		rck("inv", OFS_INV, 32'h0, RESP_OKAY);
		rck("unmapped", 8'h20, 32'h0, RESP_SLVERR);
		$display("test reset done");
	endtask : t_reset

	task t_pass;
		lvl <= 8'ha5;
		tk(3);
		chk("din", din, 8'ha5);
		axw(8'h24, 32'h1);
		chk("wr_unmapped", r, RESP_SLVERR);
		$display("test pass done");
	endtask : t_pass

	// Filter of five cycles must hold back a change for that long
	task t_filter;
		axw(OFS_FLT, 32'h7d0);
		rck("flt_sat", OFS_FLT, 32'h3e8, RESP_OKAY);
		axw(OFS_FLT, 32'h5);
		lvl <= 8'h5a;
		tk(3);
		chk("din_held", din, 8'ha5);
		tk(3);
		chk("din_new", din, 8'h5a);
		axw(OFS_FLT, 32'h1);
		lvl <= 8'ha5;
		tk(3);
		$display("test filter done");
	endtask : t_filter

	task t_select;
		logic [7:0] e;
		e = ((8'h3c & 8'h3f) | (8'ha5 & ~8'h3f)) ^ 8'h05;
		axw(OFS_SRC_LO, 32'hf);
		axw(OFS_SRC_HI, 32'h3);
		axw(OFS_INV, 32'h5);
		axw(OFS_MST, 32'h3c);
		tk(3);
		chk("din_pend", din, 8'ha5);
		rck("src_pend", OFS_SRC_LO, 32'hf, RESP_OKAY);
		rck("mst", OFS_MST, 32'h3c, RESP_OKAY);
		axw(OFS_CTRL, 32'h1);
		tk(3);
		chk("din_sel", din, e);
		rck("stat", OFS_STAT, 32'h0f3500b9, RESP_OKAY);
		axw(OFS_INV, 32'h0);
		tk(2);
		chk("din_kept", din, e);
		$display("test select done");
	endtask : t_select

	// Setting three is six control cycles of delay
	task t_alarm;
		axw(OFS_ALM, 32'h3);
		alarm_i <= 1'b1;
		tk(4);
		chk("alarm_held", alarm_o, 1'b0);
		tk(4);
		chk("alarm_set", alarm_o, 1'b1);
		alarm_i <= 1'b0;
		axw(OFS_ALM, 32'h0);
		tk(2);
		chk("alarm_clr", alarm_o, 1'b0);
		$display("test alarm done");
	endtask : t_alarm

	task test_done;
		$display("checked %0d mismatches %0d", samples_checked, fail_count);
		if (fail_count == 0 && samples_checked > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : test_done

	// Clock of 25 ns
	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end

	// Hang guard, well beyond the expected run length
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 6000) begin
			fail_count++;
			test_done;
		end
	end

	// Main sequence
	initial begin
		rst_i = 1'b1;
		alarm_i = 1'b0;
		lvl = 8'h00;
		awv = 1'b0;
		wv = 1'b0;
		arv = 1'b0;
		awa = 8'h00;
		ara = 8'h00;
		wd = 32'h0;
		fail_count = 0;
		samples_checked = 0;
		cyc = 0;
		repeat (2) @(posedge mclk_i);
		rst_i <= 1'b0;
		@(posedge mclk_i);
		t_reset;
		t_pass;
		t_filter;
		t_select;
		t_alarm;
		test_done;
	end
endmodule : testbench
